// *** verilog/cpualu_core.v ***
// Operation
// - Low-power entry clears the watchdog counter and its prescaler.
// - Sleep entry sets expiry_flag, clears power_down_flag, rest kept.
// - After low-power entry the core sleeps and stops executing commands.
// - Nibble exchange swaps a file register's nibbles; flags stay.
// - Target bit 0 sends the result to the accumulator, 1 to the register.
// - Literal minus acc goes to acc and updates carry, digit_carry, zero.
// - File minus acc follows target; updates carry, digit_carry and zero.
// - Acc xor literal writes the accumulator and changes only zero.
// - Acc xor register follows the target bit and changes only zero.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cpualu_regs.vh"
module cpualu_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         sleeping_q
);
    localparam ST_RUN   = 1'b0;
    localparam ST_SLEEP = 1'b1;

    reg  [7:0] acc_q;
    reg  [4:0] status_q;
    reg  [7:0] wdog_q;
    reg  [6:0] pre_q;
    reg  [7:0] file_mem [0:`CPUALU_FILE_DEPTH-1];
    reg        state_q;

    wire       setup   = psel & ~penable;
    wire       wr_take = psel & penable & pready & pwrite;
    wire [3:0] op      = pwdata[`CPUALU_CMD_OP_MSB:`CPUALU_CMD_OP_LSB];
    wire [7:0] lit     = pwdata[`CPUALU_CMD_LIT_MSB:`CPUALU_CMD_LIT_LSB];
    wire [6:0] adr     = pwdata[`CPUALU_CMD_ADR_MSB:`CPUALU_CMD_ADR_LSB];
    wire       dst     = pwdata[`CPUALU_CMD_DST_BIT];
    wire [7:0] fval    = file_mem[adr];
    wire       is_file = (paddr[11:9] == 3'b001) && (paddr[1:0] == 2'b00);
    wire [6:0] fidx    = paddr[8:2];

    // Subtraction a - b, returns {carry, digit_carry, result}
    function [9:0] sub8;
        input [7:0] a;
        input [7:0] b;
        reg   [8:0] full;
        reg   [4:0] low;
        begin
            full = {1'b0, a} + {1'b0, ~b} + 9'h001;
            low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
            sub8 = {full[8], low[4], full[7:0]};
        end
    endfunction

    reg  [9:0] sres;
    reg  [7:0] res;
    reg        has_res;
    reg        use_sub;
    reg        upd_z;
    reg        to_file;
    always @* begin
        sres    = 10'h000;
        res     = 8'h00;
        has_res = 1'b0;
        use_sub = 1'b0;
        upd_z   = 1'b0;
        to_file = 1'b0;
        case (op)
            `CPUALU_OP_SWAP: begin
                res     = {fval[3:0], fval[7:4]};
                has_res = 1'b1;
                to_file = dst;
            end
            `CPUALU_OP_SUBLIT: begin
                sres    = sub8(lit, acc_q);
                res     = sres[7:0];
                has_res = 1'b1;
                use_sub = 1'b1;
                upd_z   = 1'b1;
            end
            `CPUALU_OP_SUBREG: begin
                sres    = sub8(fval, acc_q);
                res     = sres[7:0];
                has_res = 1'b1;
                use_sub = 1'b1;
                upd_z   = 1'b1;
                to_file = dst;
            end
            `CPUALU_OP_XORLIT: begin
                res     = acc_q ^ lit;
                has_res = 1'b1;
                upd_z   = 1'b1;
            end
            `CPUALU_OP_XORREG: begin
                res     = acc_q ^ fval;
                has_res = 1'b1;
                upd_z   = 1'b1;
                to_file = dst;
            end
            default: begin
                res     = 8'h00;
            end
        endcase
    end

    // Commands are taken only while running; sleep blocks them
    wire cmd_go   = wr_take
                    && (paddr == `CPUALU_OFF_CMD)
                    && (state_q == ST_RUN);
    // Sleep entry decoded once for counters, flags and state
    wire sleep_go = cmd_go && (op == `CPUALU_OP_SLEEP);

    // Prescaler and watchdog counter advance while running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q  <= `CPUALU_PRE_RST;
            wdog_q <= `CPUALU_WDOG_RST;
        end else if (sleep_go) begin
            pre_q  <= `CPUALU_PRE_RST;
            wdog_q <= `CPUALU_WDOG_RST;
        end else if (state_q == ST_RUN) begin
            pre_q <= pre_q + 7'h01;
            if (pre_q == 7'h7f) begin
                wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_RUN;
            sleeping_q <= 1'b0;
            acc_q      <= `CPUALU_ACC_RST;
            status_q   <= `CPUALU_STATUS_RST;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (sleep_go) begin
                        status_q[`CPUALU_ST_EXPIRY] <= 1'b1;
                        status_q[`CPUALU_ST_PWRDN]  <= 1'b0;
                        state_q    <= ST_SLEEP;
                        sleeping_q <= 1'b1;
                    end else if (cmd_go && has_res) begin
                        if (!to_file) begin
                            acc_q <= res;
                        end
                        if (upd_z) begin
                            status_q[`CPUALU_ST_Z] <=
                                (res == 8'h00);
                        end
                        if (use_sub) begin
                            status_q[`CPUALU_ST_C]     <= sres[9];
                            status_q[`CPUALU_ST_DIGIT] <= sres[8];
                        end
                    end else if (wr_take && paddr == `CPUALU_OFF_ACC) begin
                        acc_q <= pwdata[7:0];
                    end
                end
                ST_SLEEP: begin
                    // Oscillator halted: only the wake write resumes
                    if (wr_take && paddr == `CPUALU_OFF_WAKE && pwdata[0]) begin
                        state_q    <= ST_RUN;
                        sleeping_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // File registers: command write-back or direct bus write
    always @(posedge pclk) begin
        if (cmd_go && has_res && to_file) begin
            file_mem[adr] <= res;
        end else if (wr_take && is_file) begin
            file_mem[fidx] <= pwdata[7:0];
        end
    end

    // APB slave: no wait states, error on unmapped address
    reg        mapped;
    reg [31:0] rdata;
    always @* begin
        mapped = 1'b1;
        rdata  = 32'h00000000;
        if (is_file) begin
            rdata = {24'h000000, file_mem[fidx]};
        end else begin
            case (paddr)
                `CPUALU_OFF_CMD:    rdata = 32'h00000000;
                `CPUALU_OFF_ACC:    rdata = {24'h000000, acc_q};
                `CPUALU_OFF_STATUS: rdata = {27'h0000000, status_q};
                `CPUALU_OFF_WDOG:   rdata = {17'h00000, pre_q, wdog_q};
                `CPUALU_OFF_WAKE:   rdata = {31'h00000000, sleeping_q};
                default:            mapped = 1'b0;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata <= rdata;
            end
        end
    end
endmodule // cpualu_core
`default_nettype wire

// *** verilog/cpualu_regs.vh ***
`ifndef CPUALU_REGS_VH
`define CPUALU_REGS_VH

// Register byte offsets
`define CPUALU_OFF_CMD      12'h000
`define CPUALU_OFF_ACC      12'h004
`define CPUALU_OFF_STATUS   12'h008
`define CPUALU_OFF_WDOG     12'h00c
`define CPUALU_OFF_WAKE     12'h010
`define CPUALU_OFF_FILE     12'h200

// Command register fields
`define CPUALU_CMD_OP_LSB   0
`define CPUALU_CMD_OP_MSB   3
`define CPUALU_CMD_LIT_LSB  8
`define CPUALU_CMD_LIT_MSB  15
`define CPUALU_CMD_ADR_LSB  16
`define CPUALU_CMD_ADR_MSB  22
`define CPUALU_CMD_DST_BIT  24

// Opcodes
`define CPUALU_OP_SLEEP     4'h1
`define CPUALU_OP_SWAP      4'h2
`define CPUALU_OP_SUBLIT    4'h3
`define CPUALU_OP_SUBREG    4'h4
`define CPUALU_OP_XORLIT    4'h5
`define CPUALU_OP_XORREG    4'h6

// Status bit positions
`define CPUALU_ST_C         0
`define CPUALU_ST_DIGIT     1
`define CPUALU_ST_Z         2
`define CPUALU_ST_PWRDN     3
`define CPUALU_ST_EXPIRY    4

// Reset values and file depth
`define CPUALU_STATUS_RST   5'h18
`define CPUALU_ACC_RST      8'h00
`define CPUALU_WDOG_RST     8'h00
`define CPUALU_PRE_RST      7'h00
`define CPUALU_FILE_DEPTH   128

`endif

// *** test/cpualu_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpualu_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleeping_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_w;
    logic rd_w;
    assign wr_w = psel && penable && pready && pwrite;
    assign rd_w = psel && penable && pready && !pwrite;
    a_sleep_enter: assert property (wr_w && paddr == 12'h000
        && pwdata[3:0] == 4'h1 |=> sleeping_q) else $error("no sleep");
    a_sleep_stays: assert property (sleeping_q && !(wr_w
        && paddr == 12'h010 && pwdata[0]) |=> sleeping_q) else $error("woke");
    a_wake_exit: assert property (wr_w && paddr == 12'h010
        && pwdata[0] |=> !sleeping_q) else $error("no wake");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("late ready");
    a_ready_once: assert property (pready |=> !pready)
        else $error("long ready");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("lone error");
    a_flags_sleep: assert property (rd_w && paddr == 12'h008
        && sleeping_q |-> prdata[4:3] == 2'b10) else $error("bad flags");
    a_wdog_sleep: assert property (rd_w && paddr == 12'h00c
        && sleeping_q |-> prdata[14:0] == 15'h0000) else $error("wdog");
endmodule // cpualu_checker
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleeping_q;
    logic [32:0] exp_q[$];
    logic [7:0]  acc, fv, k, a, r;
    logic [6:0]  adr;
    logic [4:0]  st;
    logic        d;
    int          err_total = 0;
    int          n_checks = 0;
    always #2 pclk = ~pclk;
    cpualu_core cpualu_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleeping_q(sleeping_q));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] dat);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic cmd(input logic [3:0] op);
        apb(1'b1, 12'h000, {7'h00, d, 1'b0, adr, k, 4'h0, op});
    endtask
    always @(posedge pclk) begin
        logic [32:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            n_checks++;
            if (e[32] ? pslverr !== 1'b1 : {pslverr, prdata} !== e) begin
                err_total++;
                $display("wrong value %0t %h %h", $time, {pslverr, prdata}, e);
            end
        end
    end
    initial begin
        void'($urandom(32'habc3));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 33'h18);
        rd(12'h004, 33'h0);
        $display("reset test done");
        st = 5'h18;
        for (int i = 0; i < 30; i++) begin
            {acc, fv, k, adr, d} = $urandom;
            if (i % 6 == 0) begin
                fv = acc;
                k = acc;
            end
            apb(1'b1, 12'h004, {24'h0, acc});
            apb(1'b1, 12'h200 + {3'h0, adr, 2'h0}, {24'h0, fv});
            a = (i % 5 % 2 == 1) ? k : fv; // Literal for ops 3 and 5
            r = (i % 5 < 3) ? a - acc : a ^ acc;
            if (i % 5 == 0) r = {fv[3:0], fv[7:4]};
            if (i % 5 == 1 || i % 5 == 2)
                st[1:0] = {a[3:0] >= acc[3:0], a >= acc};
            if (i % 5 != 0) st[2] = (r == 8'h00);
            if (i % 5 % 2 == 0 && d) fv = r;
            else acc = r;
            cmd(i % 5 + 2);
            rd(12'h004, {25'h0, acc});
            rd(12'h008, {28'h0, st});
            rd(12'h200 + {3'h0, adr, 2'h0}, {25'h0, fv});
        end
        $display("operation test done");
        cmd(4'h1);
        st[4:3] = 2'b10;
        rd(12'h008, {28'h0, st});
        rd(12'h00c, 33'h0);
        cmd(4'h5);
        apb(1'b1, 12'h004, 32'h3c);
        rd(12'h004, {25'h0, acc});
        rd(12'h010, 33'h1);
        apb(1'b1, 12'h010, 32'h1);
        rd(12'h010, 33'h0);
        rd(12'h014, {1'b1, 32'h0});
        $display("sleep test done");
        wrap_up();
    end
endmodule // tb_top
bind cpualu_core cpualu_checker cpualu_checker_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleeping_q(sleeping_q));
`default_nettype wire
